// File: bench/acs_net_ctrl.sv
`timescale 1ns/10ps
// Network controller model: sends commands and settings over the bus
module acs_net_ctrl (
  input wire logic mclk,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  // Bus idle from time zero
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end

  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= wd;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1)
      @(posedge mclk);
    rd = wb_dat_o;
    // Released lines carry junk so stale data cannot pass
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~adr;
    wb_sel_i <= 4'h0;
    wb_dat_i <= ~wd;
  endtask : xfer

  // Periodic commands; caller keeps the gap below the timeout
  task automatic send_cmds(input logic [15:0] pos, input int n,
                           input int gap);
    logic [31:0] unused;
    for (int i = 0; i < n; i++) begin
      xfer(1'b1, acs_pkg::ADDR_POS_CMD, {16'h0, pos}, unused);
      repeat (gap) @(posedge mclk);
    end
  endtask : send_cmds
endmodule : acs_net_ctrl

// File: bench/acs_supervisor_tb.sv
`timescale 1ns/10ps
module acs_supervisor_tb;
  // Short second keeps watchdog and input init runs brief
  localparam int SEC = 100;
  localparam int LIMIT = 80000;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic di_pin = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_data;
  logic motor_open, motor_close, status_led;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc_count = 0;
  int k;

  always #5 mclk = ~mclk;

  // Run time of one tenth gives one cycle per position code
  acs_supervisor #(.SEC_CYCLES(SEC), .STEP_CYCLES(1),
    .DEFAULT_RUN_TENTHS(16'h0001)) acs_supervisor_inst (.mclk(mclk),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .di_pin(di_pin), .motor_open(motor_open),
    .motor_close(motor_close), .status_led(status_led));

  acs_net_ctrl acs_net_ctrl_inst (.mclk(mclk), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] adr, input logic [15:0] val);
    acs_net_ctrl_inst.xfer(1'b1, adr, {16'h0, val}, rd_data);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp,
                        input logic [31:0] mask);
    acs_net_ctrl_inst.xfer(1'b0, adr, 32'h0, rd_data);
    check(rd_data & mask, exp);
  endtask : rd_chk

  // Poll feedback under a bounded number of reads
  task automatic wait_fb(input logic [15:0] exp, input int lim);
    for (int i = 0; i < lim; i++) begin
      acs_net_ctrl_inst.xfer(1'b0, acs_pkg::ADDR_FEEDBACK, 32'h0, rd_data);
      if (rd_data[15:0] === exp)
        break;
    end
    check(rd_data, {16'h0, exp});
  endtask : wait_fb

  // Length of a synchronisation run in cycles, capped
  task automatic sync_len(input logic close_dir);
    k = 0;
    while ((close_dir ? motor_close : motor_open) === 1'b1 && k < 30000) begin
      @(posedge mclk);
      k++;
    end
  endtask : sync_len

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge mclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    // Values after reset, one unmapped place
    rd_chk(acs_pkg::ADDR_CTRL, 32'h1, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_TIMEOUT, 32'h0, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_RUNTIME, 32'hffff, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_POLARITY, 32'h0, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_SAFETY, 32'h7fff, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_MANUAL, 32'h7fff, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_FEEDBACK, 32'h7fff, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'hff00, 32'hffffffff);
    rd_chk(8'h3c, 32'h0, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_STATUS, 32'h1, 32'h47);
    check({30'h0, motor_open, motor_close}, 32'h0);
    check({31'h0, status_led}, 32'h1);
    // Switch input after the init period, both polarities
    repeat (3 * SEC + 20) @(posedge mclk);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'h0, 32'hffff);
    di_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'h01c8, 32'hffff);
    wr(acs_pkg::ADDR_POLARITY, 16'h0001);
    repeat (10) @(posedge mclk);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'h0, 32'hffff);
    wr(acs_pkg::ADDR_POLARITY, 16'h0000);
    // Invalid safety: first value stored, no move
    wr(acs_pkg::ADDR_POS_CMD, 16'h2710);
    repeat (20) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h0);
    rd_chk(acs_pkg::ADDR_FEEDBACK, 32'h2710, 32'hffffffff);
    // Run time of two tenths halves the stepping rate
    wr(acs_pkg::ADDR_RUNTIME, 16'h0002);
    wr(acs_pkg::ADDR_POS_CMD, 16'h2800);
    repeat (4) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h2);
    repeat (300) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h2);
    wait_fb(16'h2800, 200);
    wr(acs_pkg::ADDR_RUNTIME, 16'hffff);
    // 0.9 s truncates to zero seconds, so no expiry
    wr(acs_pkg::ADDR_TIMEOUT, 16'h0009);
    wr(acs_pkg::ADDR_POS_CMD, 16'h2800);
    repeat (4 * SEC) @(posedge mclk);
    rd_chk(acs_pkg::ADDR_STATUS, 32'h0, 32'h80);
    // Two-second watchdog fed, then starved under manual
    wr(acs_pkg::ADDR_SAFETY, acs_pkg::POS_ZERO);
    wr(acs_pkg::ADDR_TIMEOUT, 16'h0014);
    acs_net_ctrl_inst.send_cmds(16'h2800, 8, SEC / 2);
    rd_chk(acs_pkg::ADDR_STATUS, 32'h0, 32'h80);
    wr(acs_pkg::ADDR_MANUAL, 16'h2800);
    repeat (4 * SEC) @(posedge mclk);
    rd_chk(acs_pkg::ADDR_STATUS, 32'h80, 32'h80);
    check({30'h0, motor_open, motor_close}, 32'h0);
    wr(acs_pkg::ADDR_MANUAL, 16'h7fff);
    repeat (4) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h1);
    // A later sync gives way to a fresh command
    repeat (50) @(posedge mclk);
    wr(acs_pkg::ADDR_POS_CMD, 16'h27c0);
    wait_fb(16'h27c0, 200);
    rd_chk(acs_pkg::ADDR_STATUS, 32'h1, 32'h87);
    // Offline in mid-move
    wr(acs_pkg::ADDR_POS_CMD, 16'h1000);
    repeat (10) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h1);
    wr(acs_pkg::ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h0);
    check({31'h0, status_led}, 32'h0);
    rd_chk(acs_pkg::ADDR_FEEDBACK, 32'h7fff, 32'hffffffff);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'hff00, 32'hff00);
    // No resends during the long boot runs, so watchdog off
    wr(acs_pkg::ADDR_TIMEOUT, 16'h0000);
    wr(acs_pkg::ADDR_POS_CMD, 16'h3000);
    repeat (10) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h0);
    // Back online: boot sync to 0 % ignores a command
    wr(acs_pkg::ADDR_CTRL, 16'h0001);
    repeat (3) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h1);
    check({31'h0, status_led}, 32'h1);
    rd_chk(acs_pkg::ADDR_DI_REPORT, 32'hff00, 32'hffff);
    wr(acs_pkg::ADDR_POS_CMD, 16'h0100);
    sync_len(1'b1);
    check({31'h0, k > 25900 && k < 26100}, 32'h1);
    wait_fb(16'h0100, 200);
    // Boot sync to 100 % then waits with no command
    wr(acs_pkg::ADDR_SAFETY, acs_pkg::POS_FULL);
    wr(acs_pkg::ADDR_CTRL, 16'h0000);
    wr(acs_pkg::ADDR_CTRL, 16'h0001);
    repeat (3) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h2);
    sync_len(1'b0);
    check({31'h0, k > 25900 && k < 26100}, 32'h1);
    repeat (20) @(posedge mclk);
    check({30'h0, motor_open, motor_close}, 32'h0);
    rd_chk(acs_pkg::ADDR_FEEDBACK, 32'h4e20, 32'hffffffff);
    stop_test();
  end
endmodule : acs_supervisor_tb

// File: inc/acs_pkg.sv
package acs_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_SAFETY = 8'h08;
  localparam logic [7:0] ADDR_RUNTIME = 8'h0c;
  localparam logic [7:0] ADDR_POLARITY = 8'h10;
  localparam logic [7:0] ADDR_POS_CMD = 8'h14;
  localparam logic [7:0] ADDR_MANUAL = 8'h18;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h1c;
  localparam logic [7:0] ADDR_DI_REPORT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  // Position codes, 0.005 % per step
  localparam logic [15:0] POS_ZERO = 16'h0000;
  localparam logic [15:0] POS_FULL = 16'h4e20;
  localparam logic [15:0] POS_INVALID = 16'h7fff;
  localparam logic [15:0] SYNC_STEPS = 16'h6590;
  // Values after reset, plus the input report value for on
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [15:0] RUNTIME_INVALID = 16'hffff;
  localparam logic [7:0] DI_STATE_INVALID = 8'hff;
  localparam logic [7:0] DI_VALUE_ON = 8'hc8;
  localparam logic [7:0] DI_VALUE_OFF = 8'h00;
  // Timing
  localparam int CLK_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYC = SEC_NS / CLK_NS;
  localparam int TENTH_NS = 100000000;
  localparam int STEP_CYC = (TENTH_NS / CLK_NS) / 20000;
  localparam int DI_INIT_S = 3;
  localparam int TENTHS_PER_S = 10;

  // Configuration carried from the register file to the control logic
  typedef struct packed {
    logic online;
    logic di_inverted;
    logic [15:0] timeout;
    logic [15:0] safety;
    logic [15:0] run_time;
  } acs_cfg_s;

  typedef enum logic [2:0] {
    ST_BOOT_SYNC,
    ST_IDLE,
    ST_MOVE,
    ST_SYNC,
    ST_OFFLINE
  } acs_state_e;
endpackage : acs_pkg

// File: rtl/acs_supervisor.sv
// Notes on behaviour
// - Timeout below one second disables watchdog; one second or more enables
// - Only whole seconds of timeout used
// - Watchdog starts after first position command
// - Hold safety position until first command
// - Watchdog runs under manual; safety on release
// - Command, manual, feedback reset to invalid
// - Input reports state -1 during init
// - Timeout zero, not inverted, runtime invalid
// - Invalid safety: first value stored, no move
// - Safety 0 %: sync closed, then follow
// - Safety 100 %: sync open, then follow
// - Boot sync uninterruptible; later sync interruptible
// - Going offline halts application, stops motor
// - Offline switches status indicator off
// - Offline sets position feedback invalid
// - Offline sets input state invalid
// - Going online restarts like reset
// - Timeout expiry drives to safety position
// - Sync runs 130 % stroke; else stop
`timescale 1ns/10ps
module acs_supervisor #(
  parameter int SEC_CYCLES = acs_pkg::SEC_CYC,
  parameter int STEP_CYCLES = acs_pkg::STEP_CYC,
  parameter logic [15:0] DEFAULT_RUN_TENTHS = 16'h05dc
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic di_pin,
  output logic motor_open,
  output logic motor_close,
  output logic status_led
);
  acs_pkg::acs_cfg_s cfg;
  acs_pkg::acs_state_e state;
  logic [15:0] position_command;
  logic [15:0] manual_position;
  logic [15:0] pos;
  logic pos_known;
  logic have_cmd;
  logic offline_view;
  logic [2:0] di_sync;
  logic di_level;
  logic [31:0] sec_cnt;
  logic [15:0] wd_cnt;
  logic wd_expired;
  logic safety_done;
  logic [31:0] step_cnt;
  logic [15:0] sync_cnt;
  logic dir_open;
  logic online_q;
  logic [1:0] di_init_cnt;
  logic init_done;
  logic [7:0] di_value;
  logic [7:0] di_state;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes commit on the ack edge, while the master still holds data
  wire wr_ack = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire wr_lo = wr_ack & wb_sel_i[0];
  wire wr_hi = wr_ack & wb_sel_i[1];
  wire wr_any = wr_lo | wr_hi;
  wire hit_ctrl = wb_adr_i == acs_pkg::ADDR_CTRL;
  wire hit_timeout = wb_adr_i == acs_pkg::ADDR_TIMEOUT;
  wire hit_safety = wb_adr_i == acs_pkg::ADDR_SAFETY;
  wire hit_runtime = wb_adr_i == acs_pkg::ADDR_RUNTIME;
  wire hit_polarity = wb_adr_i == acs_pkg::ADDR_POLARITY;
  wire hit_cmd = wb_adr_i == acs_pkg::ADDR_POS_CMD;
  wire hit_manual = wb_adr_i == acs_pkg::ADDR_MANUAL;
  wire [15:0] wdata = wb_dat_i[15:0];

  // Position values outside the stroke count as invalid
  wire cmd_write = wr_any & hit_cmd & cfg.online;
  wire cmd_ev = cmd_write & (wdata <= acs_pkg::POS_FULL);
  wire man_write = wr_any & hit_manual & cfg.online;
  wire man_valid = manual_position <= acs_pkg::POS_FULL;
  wire man_ev = man_write & (wdata <= acs_pkg::POS_FULL);
  wire go_offline = online_q & ~cfg.online;
  wire go_online = ~online_q & cfg.online;

  // Safety setting decode
  wire safe_close = cfg.safety == acs_pkg::POS_ZERO;
  wire safe_open = cfg.safety == acs_pkg::POS_FULL;
  wire safe_sync = safe_close | safe_open;

  // Only whole seconds matter; tenths are dropped
  wire [15:0] timeout_s = cfg.timeout / 16'(acs_pkg::TENTHS_PER_S);
  wire wd_enabled = timeout_s != 16'h0000;
  wire sec_tick = sec_cnt == 32'(SEC_CYCLES - 1);
  wire wd_fire = wd_enabled & have_cmd & sec_tick & ~cmd_ev
    & (wd_cnt + 16'h0001 >= timeout_s);
  // Manual operation masks expiry until released
  wire wd_hold = wd_expired & ~man_valid;

  // Target: manual first, then network command unless watchdog holds
  wire [15:0] target = man_valid ? manual_position : position_command;
  wire target_ok = man_valid | (have_cmd & ~wd_hold);
  wire [15:0] run_tenths = (cfg.run_time == acs_pkg::RUNTIME_INVALID)
    ? DEFAULT_RUN_TENTHS : cfg.run_time;
  wire [31:0] step_len = 32'(run_tenths) * 32'(STEP_CYCLES);
  wire step_tick = step_cnt + 32'h0000_0001 >= step_len;
  wire need_move = pos_known & target_ok & (target != pos);
  wire start_safety = wd_hold & ~safety_done;
  wire [15:0] sync_end = safe_open ? acs_pkg::POS_FULL : acs_pkg::POS_ZERO;
  // Unknown position reads invalid, not a stale zero
  wire fb_invalid = offline_view | ~pos_known;

  // Register file; writes land on the ack edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg.online <= 1'b1;
      cfg.di_inverted <= 1'b0;
      cfg.timeout <= acs_pkg::TIMEOUT_RST;
      cfg.safety <= acs_pkg::POS_INVALID;
      cfg.run_time <= acs_pkg::RUNTIME_INVALID;
    end else begin
      if (wr_lo & hit_ctrl) begin
        cfg.online <= wb_dat_i[0];
      end
      if (wr_lo & hit_polarity) begin
        cfg.di_inverted <= wb_dat_i[0];
      end
      if (hit_timeout) begin
        if (wr_lo) cfg.timeout[7:0] <= wdata[7:0];
        if (wr_hi) cfg.timeout[15:8] <= wdata[15:8];
      end
      if (hit_safety) begin
        if (wr_lo) cfg.safety[7:0] <= wdata[7:0];
        if (wr_hi) cfg.safety[15:8] <= wdata[15:8];
      end
      if (hit_runtime) begin
        if (wr_lo) cfg.run_time[7:0] <= wdata[7:0];
        if (wr_hi) cfg.run_time[15:8] <= wdata[15:8];
      end
    end
  end

  // Read mux, registered with the ack
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      acs_pkg::ADDR_CTRL: rd_mux = {31'h0, cfg.online};
      acs_pkg::ADDR_TIMEOUT: rd_mux = {16'h0, cfg.timeout};
      acs_pkg::ADDR_SAFETY: rd_mux = {16'h0, cfg.safety};
      acs_pkg::ADDR_RUNTIME: rd_mux = {16'h0, cfg.run_time};
      acs_pkg::ADDR_POLARITY: rd_mux = {31'h0, cfg.di_inverted};
      acs_pkg::ADDR_POS_CMD: rd_mux = {16'h0, position_command};
      acs_pkg::ADDR_MANUAL: rd_mux = {16'h0, manual_position};
      acs_pkg::ADDR_FEEDBACK:
        rd_mux = {16'h0, fb_invalid ? acs_pkg::POS_INVALID : pos};
      acs_pkg::ADDR_DI_REPORT: rd_mux = {16'h0, di_state, di_value};
      acs_pkg::ADDR_STATUS: rd_mux = {24'h0, wd_expired, have_cmd,
        pos_known, 2'h0, state};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses still ack, reading zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      online_q <= 1'b1;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
      online_q <= cfg.online;
    end
  end

  // Received values; restart on online puts them back to invalid
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      position_command <= acs_pkg::POS_INVALID;
      manual_position <= acs_pkg::POS_INVALID;
      have_cmd <= 1'b0;
    end else if (go_online) begin
      position_command <= acs_pkg::POS_INVALID;
      manual_position <= acs_pkg::POS_INVALID;
      have_cmd <= 1'b0;
    end else begin
      if (cmd_write) position_command <= wdata;
      if (man_write) manual_position <= wdata;
      if (cmd_ev) have_cmd <= 1'b1;
    end
  end

  // Second prescaler and watchdog; a command or restart clear wins over an expiry set
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sec_cnt <= 32'h0000_0000;
      wd_cnt <= 16'h0000;
      wd_expired <= 1'b0;
    end else if (go_online | ~cfg.online) begin
      sec_cnt <= 32'h0000_0000;
      wd_cnt <= 16'h0000;
      wd_expired <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      if (cmd_ev) begin
        wd_cnt <= 16'h0000;
      end else if (have_cmd & wd_enabled & sec_tick & ~wd_fire) begin
        wd_cnt <= wd_cnt + 16'h0001;
      end
      if (wd_fire) begin
        wd_expired <= 1'b1;
      end else if (cmd_ev | ~wd_enabled) begin
        wd_expired <= 1'b0;
      end
    end
  end

  // Motor control; a run to a safety end covers 130 % of the stroke
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= acs_pkg::ST_BOOT_SYNC;
      pos <= acs_pkg::POS_ZERO;
      pos_known <= 1'b0;
      safety_done <= 1'b0;
      step_cnt <= 32'h0000_0000;
      sync_cnt <= 16'h0000;
      dir_open <= 1'b0;
      offline_view <= 1'b0;
    end else begin
      step_cnt <= step_tick ? 32'h0000_0000 : step_cnt + 32'h0000_0001;
      if (cmd_ev) safety_done <= 1'b0;
      case (state)
        acs_pkg::ST_BOOT_SYNC: begin
          // No command can cut this run short
          if (go_offline) begin
            state <= acs_pkg::ST_OFFLINE;
            offline_view <= 1'b1;
          end else if (!safe_sync) begin
            state <= acs_pkg::ST_IDLE;
          end else begin
            dir_open <= safe_open;
            if (step_tick) begin
              sync_cnt <= sync_cnt + 16'h0001;
            end
            if (step_tick && sync_cnt + 16'h0001 >= acs_pkg::SYNC_STEPS)
            begin
              pos <= sync_end;
              pos_known <= 1'b1;
              sync_cnt <= 16'h0000;
              state <= acs_pkg::ST_IDLE;
            end
          end
        end
        acs_pkg::ST_IDLE: begin
          if (go_offline) begin
            state <= acs_pkg::ST_OFFLINE;
            offline_view <= 1'b1;
          end else if (!pos_known && (cmd_ev || man_ev)) begin
            pos <= wdata;
            pos_known <= 1'b1;
          end else if (start_safety) begin
            safety_done <= 1'b1;
            sync_cnt <= 16'h0000;
            if (safe_sync) begin
              // Direction set on entry, no wrong-way first cycle
              dir_open <= safe_open;
              state <= acs_pkg::ST_SYNC;
            end
          end else if (need_move) begin
            dir_open <= target > pos;
            state <= acs_pkg::ST_MOVE;
          end
        end
        acs_pkg::ST_MOVE: begin
          if (go_offline) begin
            state <= acs_pkg::ST_OFFLINE;
            offline_view <= 1'b1;
          end else if (start_safety || !target_ok) begin
            state <= acs_pkg::ST_IDLE;
          end else if (target == pos) begin
            state <= acs_pkg::ST_IDLE;
          end else if (step_tick) begin
            dir_open <= target > pos;
            pos <= (target > pos) ? pos + 16'h0001 : pos - 16'h0001;
          end
        end
        acs_pkg::ST_SYNC: begin
          if (go_offline) begin
            state <= acs_pkg::ST_OFFLINE;
            offline_view <= 1'b1;
          end else if (cmd_ev || man_valid) begin
            state <= acs_pkg::ST_IDLE;
          end else begin
            dir_open <= safe_open;
            if (step_tick) begin
              sync_cnt <= sync_cnt + 16'h0001;
              if (safe_open && pos < acs_pkg::POS_FULL) begin
                pos <= pos + 16'h0001;
              end else if (!safe_open && pos > acs_pkg::POS_ZERO) begin
                pos <= pos - 16'h0001;
              end
            end
            if (step_tick && sync_cnt + 16'h0001 >= acs_pkg::SYNC_STEPS)
            begin
              pos <= sync_end;
              state <= acs_pkg::ST_IDLE;
            end
          end
        end
        acs_pkg::ST_OFFLINE: begin
          if (go_online) begin
            state <= acs_pkg::ST_BOOT_SYNC;
            dir_open <= safe_open;
            pos_known <= 1'b0;
            safety_done <= 1'b0;
            sync_cnt <= 16'h0000;
            offline_view <= 1'b0;
          end
        end
        default: state <= acs_pkg::ST_IDLE;
      endcase
    end
  end

  // Motor drive and status indicator
  wire running = (state == acs_pkg::ST_MOVE)
    || (state == acs_pkg::ST_SYNC)
    || ((state == acs_pkg::ST_BOOT_SYNC) && safe_sync);
  assign motor_open = running & dir_open;
  assign motor_close = running & ~dir_open;
  assign status_led = state != acs_pkg::ST_OFFLINE;

  // Pin synchroniser; change taken when stages two and three agree
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      di_sync <= 3'h0;
      di_level <= 1'b0;
    end else begin
      di_sync <= {di_sync[1:0], di_pin};
      if (di_sync[1] == di_sync[2]) di_level <= di_sync[2];
    end
  end

  // Input report; init window re-runs after every restart
  wire di_active = di_level ^ cfg.di_inverted;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      di_init_cnt <= 2'h0;
      init_done <= 1'b0;
      di_value <= acs_pkg::DI_VALUE_OFF;
      di_state <= acs_pkg::DI_STATE_INVALID;
    end else if (go_online || !cfg.online) begin
      di_init_cnt <= 2'h0;
      init_done <= 1'b0;
      di_value <= acs_pkg::DI_VALUE_OFF;
      di_state <= acs_pkg::DI_STATE_INVALID;
    end else if (!init_done) begin
      if (sec_tick) di_init_cnt <= di_init_cnt + 2'h1;
      if (sec_tick && di_init_cnt == 2'(acs_pkg::DI_INIT_S - 1)) begin
        init_done <= 1'b1;
      end
    end else begin
      di_value <= di_active ? acs_pkg::DI_VALUE_ON : acs_pkg::DI_VALUE_OFF;
      di_state <= {7'h00, di_active};
    end
  end

  // Assertions
  a_wd_zero_off: assert property (@(posedge mclk) disable iff (reset)
    !wd_enabled |=> !wd_expired)
    else $error("watchdog expired with zero timeout");
  a_wd_needs_cmd: assert property (@(posedge mclk) disable iff (reset)
    !have_cmd |-> !wd_fire)
    else $error("watchdog fired before first command");
  a_wd_restart: assert property (@(posedge mclk) disable iff (reset)
    cmd_ev && cfg.online && !go_online |=> wd_cnt == 16'h0000)
    else $error("command did not restart watchdog count");
  a_manual_hold: assert property (@(posedge mclk) disable iff (reset)
    man_valid && state == acs_pkg::ST_IDLE |=> state != acs_pkg::ST_SYNC)
    else $error("safety run started under manual operation");
  a_boot_no_cut: assert property (@(posedge mclk) disable iff (reset)
    state == acs_pkg::ST_BOOT_SYNC && safe_sync && !go_offline
    && sync_cnt + 16'h0001 < acs_pkg::SYNC_STEPS
    |=> state == acs_pkg::ST_BOOT_SYNC)
    else $error("boot synchronisation interrupted");
  a_later_cut: assert property (@(posedge mclk) disable iff (reset)
    state == acs_pkg::ST_SYNC && cmd_ev |=> state == acs_pkg::ST_IDLE)
    else $error("later synchronisation not interruptible");
  a_offline_stop: assert property (@(posedge mclk) disable iff (reset)
    go_offline |=> !motor_open && !motor_close && !status_led)
    else $error("motor or indicator active after going offline");
  a_offline_state: assert property (@(posedge mclk) disable iff (reset)
    go_offline |=> di_state == acs_pkg::DI_STATE_INVALID
    && offline_view)
    else $error("offline reports not invalid");
  a_invalid_still: assert property (@(posedge mclk) disable iff (reset)
    !safe_sync && !pos_known |-> !motor_open && !motor_close)
    else $error("motor moved before first value with invalid safety");
endmodule : acs_supervisor
